// ===== pbmr_regs.sv
// phy basic management register bank with indexed access
`include "pbmr_consts.svh"
module pbmr_regs #(
	parameter int DATA_W = 16,
	parameter int INDEX_W = 5
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// indexed management access from the mac
	input wire logic [INDEX_W-1:0] index_in,
	input wire logic wr_strobe_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic rd_strobe_in,
	output logic [DATA_W-1:0] rd_data_out,
	output logic rd_valid_out,
	// state reported by the phy core
	input wire logic link_up_in,
	input wire logic remote_fault_in,
	input wire logic jabber_in,
	input wire logic an_complete_in,
	input wire logic an_speed_100_in,
	input wire logic an_full_duplex_in,
	input wire logic [1:0] partner_pause_in,
	// controls driven into the phy core
	output logic soft_reset_out,
	output logic an_restart_out,
	output logic an_enable_out,
	output logic loopback_out,
	output logic power_down_out,
	output logic col_test_out,
	output logic speed_100_out,
	output logic full_duplex_out,
	output logic [1:0] pause_cfg_out,
	output logic [DATA_W-1:0] advert_out
);
	//----------------------------------------------------------------------
	// declarations
	//----------------------------------------------------------------------
	localparam int CNT_W = 8; // soft reset counter width
	localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(`PBMR_SOFT_RESET_CYCLES - 1);

	pbmr_pkg::pbmr_state_t state; // soft reset sequencer
	logic [CNT_W-1:0] rst_cnt; // cycles spent in soft reset
	logic ctl_loopback; // loopback select
	logic ctl_speed_100; // manual speed
	logic ctl_an_enable; // autonegotiation enable
	logic ctl_power_down; // general power down
	logic ctl_an_restart; // self-clearing restart
	logic ctl_full_duplex; // manual duplex
	logic ctl_col_test; // collision test
	logic [DATA_W-1:0] id_high; // identifier one
	logic [DATA_W-1:0] id_low; // identifier two
	logic [DATA_W-1:0] advert; // advertisement register
	logic an_done; // autonegotiation complete flag
	logic flag_remote_fault; // latched remote fault
	logic flag_jabber; // latched jabber
	logic flag_link; // latched link status
	logic wr_ok; // write accepted this cycle
	logic status_read; // status register read
	logic [DATA_W-1:0] ctl_word; // assembled control read value
	logic [DATA_W-1:0] sts_word; // assembled status read value
	logic [1:0] next_pause; // resolved pause setting

	//----------------------------------------------------------------------
	// decode helper
	//----------------------------------------------------------------------
	// true when an access hits the given register index
	function automatic logic pbmr_hit(input logic [INDEX_W-1:0] idx,
		input logic [4:0] target);
		pbmr_hit = (idx == INDEX_W'(target));
	endfunction

	//----------------------------------------------------------------------
	// access qualifiers
	//----------------------------------------------------------------------
	// writes are ignored while a soft reset is running
	assign wr_ok = wr_strobe_in && (state == pbmr_pkg::PBMR_RUN);
	// a status read clears the latched flags
	assign status_read = rd_strobe_in && pbmr_hit(index_in, `PBMR_IDX_STATUS);

	//----------------------------------------------------------------------
	// soft reset sequencer
	//----------------------------------------------------------------------
	// a write with the reset bit set runs a fixed-length reset
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			state <= pbmr_pkg::PBMR_RUN;
			rst_cnt <= '0;
		end
		else
		begin
			unique case (state)
				pbmr_pkg::PBMR_RUN:
				begin
					rst_cnt <= '0;
					// other bits of that write are not used
					if (wr_ok && pbmr_hit(index_in, `PBMR_IDX_CONTROL) &&
						wr_data_in[`PBMR_CTL_SOFT_RESET])
						state <= pbmr_pkg::PBMR_SOFT_RESET;
				end
				pbmr_pkg::PBMR_SOFT_RESET:
				begin
					// bit clears by itself when the count ends
					if (rst_cnt == RST_LAST)
						state <= pbmr_pkg::PBMR_RUN;
					else
						rst_cnt <= rst_cnt + CNT_W'(1);
				end
			endcase
		end
	end

	//----------------------------------------------------------------------
	// control register
	//----------------------------------------------------------------------
	// read/write control fields, returned to defaults by soft reset
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in || state == pbmr_pkg::PBMR_SOFT_RESET)
		begin
			ctl_loopback <= 1'b0;
			ctl_speed_100 <= `PBMR_CTL_RESET_SPEED;
			ctl_an_enable <= `PBMR_CTL_RESET_AN_ENABLE;
			ctl_power_down <= 1'b0;
			ctl_full_duplex <= 1'b0;
			ctl_col_test <= 1'b0;
		end
		else if (wr_ok && pbmr_hit(index_in, `PBMR_IDX_CONTROL) &&
			!wr_data_in[`PBMR_CTL_SOFT_RESET])
		begin
			ctl_loopback <= wr_data_in[`PBMR_CTL_LOOPBACK];
			ctl_speed_100 <= wr_data_in[`PBMR_CTL_SPEED_100];
			ctl_an_enable <= wr_data_in[`PBMR_CTL_AN_ENABLE];
			// relies on enable having been cleared beforehand
			ctl_power_down <= wr_data_in[`PBMR_CTL_POWER_DOWN];
			ctl_full_duplex <= wr_data_in[`PBMR_CTL_FULL_DUPLEX];
			ctl_col_test <= wr_data_in[`PBMR_CTL_COL_TEST];
		end
	end

	//----------------------------------------------------------------------
	// restart autonegotiation
	//----------------------------------------------------------------------
	// one-cycle restart, the bit then clears by itself
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			ctl_an_restart <= 1'b0;
		else if (ctl_an_restart)
			ctl_an_restart <= 1'b0;
		else
			ctl_an_restart <= wr_ok && pbmr_hit(index_in, `PBMR_IDX_CONTROL) &&
				!wr_data_in[`PBMR_CTL_SOFT_RESET] &&
				wr_data_in[`PBMR_CTL_AN_RESTART];
	end

	//----------------------------------------------------------------------
	// identifier registers
	//----------------------------------------------------------------------
	// writable identity words, kept across soft reset
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			id_high <= `PBMR_ID_HIGH_RESET;
			id_low <= `PBMR_ID_LOW_RESET;
		end
		else if (wr_ok)
		begin
			if (pbmr_hit(index_in, `PBMR_IDX_ID_HIGH))
				id_high <= wr_data_in; // oui bits 3 to 18
			if (pbmr_hit(index_in, `PBMR_IDX_ID_LOW))
				id_low <= wr_data_in; // oui, model, revision
		end
	end

	//----------------------------------------------------------------------
	// advertisement register
	//----------------------------------------------------------------------
	// reserved bits stay zero, the rest is writable
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in || state == pbmr_pkg::PBMR_SOFT_RESET)
			advert <= `PBMR_ADV_RESET;
		else if (wr_ok && pbmr_hit(index_in, `PBMR_IDX_ADVERT))
			advert <= wr_data_in & `PBMR_ADV_WRITE_MASK;
	end

	//----------------------------------------------------------------------
	// latched status flags
	//----------------------------------------------------------------------
	// remote fault, latching high
	pbmr_latch_flag #(
		.LATCH_LOW(1'b0)
	) u_remote_fault (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.level_in(remote_fault_in),
		.clear_in(status_read),
		.flag_out(flag_remote_fault)
	);
	// jabber, latching high
	pbmr_latch_flag #(
		.LATCH_LOW(1'b0)
	) u_jabber (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.level_in(jabber_in),
		.clear_in(status_read),
		.flag_out(flag_jabber)
	);
	// link status, latching low
	pbmr_latch_flag #(
		.LATCH_LOW(1'b1)
	) u_link (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.level_in(link_up_in),
		.clear_in(status_read),
		.flag_out(flag_link)
	);

	// live completion level, cleared by reset or restart
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in || state == pbmr_pkg::PBMR_SOFT_RESET || ctl_an_restart)
			an_done <= 1'b0;
		else
			an_done <= an_complete_in && ctl_an_enable;
	end

	//----------------------------------------------------------------------
	// read value assembly
	//----------------------------------------------------------------------
	// control word, reserved bits zero
	always_comb
	begin
		ctl_word = '0;
		ctl_word[`PBMR_CTL_SOFT_RESET] = (state == pbmr_pkg::PBMR_SOFT_RESET);
		ctl_word[`PBMR_CTL_LOOPBACK] = ctl_loopback;
		ctl_word[`PBMR_CTL_SPEED_100] = ctl_speed_100;
		ctl_word[`PBMR_CTL_AN_ENABLE] = ctl_an_enable;
		ctl_word[`PBMR_CTL_POWER_DOWN] = ctl_power_down;
		ctl_word[`PBMR_CTL_AN_RESTART] = ctl_an_restart;
		ctl_word[`PBMR_CTL_FULL_DUPLEX] = ctl_full_duplex;
		ctl_word[`PBMR_CTL_COL_TEST] = ctl_col_test;
	end

	// status word, fixed abilities plus live and latched bits
	always_comb
	begin
		sts_word = `PBMR_STS_FIXED;
		sts_word[`PBMR_STS_AN_COMPLETE] = an_done;
		sts_word[`PBMR_STS_REMOTE_FAULT] = flag_remote_fault;
		sts_word[`PBMR_STS_LINK_UP] = flag_link;
		sts_word[`PBMR_STS_JABBER] = flag_jabber;
	end

	//----------------------------------------------------------------------
	// read port
	//----------------------------------------------------------------------
	// data one cycle after the strobe, unmapped indices read zero
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			rd_data_out <= '0;
			rd_valid_out <= 1'b0;
		end
		else
		begin
			rd_valid_out <= rd_strobe_in;
			if (rd_strobe_in)
			begin
				if (pbmr_hit(index_in, `PBMR_IDX_CONTROL))
					rd_data_out <= ctl_word;
				else if (pbmr_hit(index_in, `PBMR_IDX_STATUS))
					rd_data_out <= sts_word;
				else if (pbmr_hit(index_in, `PBMR_IDX_ID_HIGH))
					rd_data_out <= id_high;
				else if (pbmr_hit(index_in, `PBMR_IDX_ID_LOW))
					rd_data_out <= id_low;
				else if (pbmr_hit(index_in, `PBMR_IDX_ADVERT))
					rd_data_out <= advert;
				else
					rd_data_out <= '0;
			end
		end
	end

	//----------------------------------------------------------------------
	// pause resolution
	//----------------------------------------------------------------------
	// when both modes are advertised, pick at most one
	always_comb
	begin
		unique case (pbmr_pkg::pbmr_pause_t'(advert[`PBMR_ADV_PAUSE_LSB +: 2]))
			pbmr_pkg::PBMR_PAUSE_BOTH:
			begin
				if (partner_pause_in[0])
					next_pause = pbmr_pkg::PBMR_PAUSE_SYM;
				else if (partner_pause_in[1])
					next_pause = pbmr_pkg::PBMR_PAUSE_ASYM;
				else
					next_pause = pbmr_pkg::PBMR_PAUSE_NONE;
			end
			pbmr_pkg::PBMR_PAUSE_SYM:
				next_pause = partner_pause_in[0] ? pbmr_pkg::PBMR_PAUSE_SYM :
					pbmr_pkg::PBMR_PAUSE_NONE;
			pbmr_pkg::PBMR_PAUSE_ASYM:
				next_pause = partner_pause_in[1] ? pbmr_pkg::PBMR_PAUSE_ASYM :
					pbmr_pkg::PBMR_PAUSE_NONE;
			pbmr_pkg::PBMR_PAUSE_NONE:
				next_pause = pbmr_pkg::PBMR_PAUSE_NONE;
		endcase
	end

	//----------------------------------------------------------------------
	// core control outputs
	//----------------------------------------------------------------------
	// registered controls toward the phy core
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			soft_reset_out <= 1'b0;
			an_restart_out <= 1'b0;
			an_enable_out <= 1'b0;
			loopback_out <= 1'b0;
			power_down_out <= 1'b0;
			col_test_out <= 1'b0;
			speed_100_out <= 1'b0;
			full_duplex_out <= 1'b0;
			pause_cfg_out <= 2'h0;
			advert_out <= '0;
		end
		else
		begin
			soft_reset_out <= (state == pbmr_pkg::PBMR_SOFT_RESET);
			an_restart_out <= ctl_an_restart;
			an_enable_out <= ctl_an_enable;
			loopback_out <= ctl_loopback;
			power_down_out <= ctl_power_down;
			col_test_out <= ctl_col_test;
			// manual bits ignored while autonegotiation is on
			speed_100_out <= ctl_an_enable ? an_speed_100_in : ctl_speed_100;
			full_duplex_out <= ctl_an_enable ? an_full_duplex_in :
				ctl_full_duplex;
			// pause applies only once negotiation has completed
			pause_cfg_out <= an_done ? next_pause : 2'h0;
			advert_out <= advert;
		end
	end
endmodule // pbmr_regs

// ===== pbmr_consts.svh
// register indices, field positions, reset values and timing counts of the phy register bank
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef PBMR_CONSTS_SVH
`define PBMR_CONSTS_SVH

//----------------------------------------------------------------------
// register indices
//----------------------------------------------------------------------
`define PBMR_IDX_CONTROL 5'h00
`define PBMR_IDX_STATUS 5'h01
`define PBMR_IDX_ID_HIGH 5'h02
`define PBMR_IDX_ID_LOW 5'h03
`define PBMR_IDX_ADVERT 5'h04

//----------------------------------------------------------------------
// control field positions
//----------------------------------------------------------------------
`define PBMR_CTL_SOFT_RESET 15
`define PBMR_CTL_LOOPBACK 14
`define PBMR_CTL_SPEED_100 13
`define PBMR_CTL_AN_ENABLE 12
`define PBMR_CTL_POWER_DOWN 11
`define PBMR_CTL_AN_RESTART 9
`define PBMR_CTL_FULL_DUPLEX 8
`define PBMR_CTL_COL_TEST 7

//----------------------------------------------------------------------
// status field positions and fixed ability bits
//----------------------------------------------------------------------
`define PBMR_STS_AN_COMPLETE 5
`define PBMR_STS_REMOTE_FAULT 4
`define PBMR_STS_LINK_UP 2
`define PBMR_STS_JABBER 1
`define PBMR_STS_FIXED 16'h7809

//----------------------------------------------------------------------
// advertisement field positions, masks and reset values
//----------------------------------------------------------------------
`define PBMR_ADV_REMOTE_FAULT 13
`define PBMR_ADV_PAUSE_LSB 10
`define PBMR_ADV_WRITE_MASK 16'h2DFF
`define PBMR_ADV_RESET 16'h01E1
`define PBMR_CTL_RESET_SPEED 1'h1
`define PBMR_CTL_RESET_AN_ENABLE 1'h1

//----------------------------------------------------------------------
// identifier reset values, arbitrary neutral codes
//----------------------------------------------------------------------
`define PBMR_ID_HIGH_RESET 16'h1234
`define PBMR_ID_LOW_RESET 16'h5670

//----------------------------------------------------------------------
// soft reset duration
//----------------------------------------------------------------------
`define PBMR_CLK_PERIOD_NS 10
`define PBMR_SOFT_RESET_NS 200
`define PBMR_SOFT_RESET_CYCLES \
	((`PBMR_SOFT_RESET_NS + `PBMR_CLK_PERIOD_NS - 1) / `PBMR_CLK_PERIOD_NS)

`endif

// ===== pbmr_pkg.sv
// types shared by the phy register bank
package pbmr_pkg;
	// soft reset sequencer states
	typedef enum logic [0:0] {
		PBMR_RUN = 1'b0,
		PBMR_SOFT_RESET = 1'b1
	} pbmr_state_t;
	// pause advertisement codes
	typedef enum logic [1:0] {
		PBMR_PAUSE_NONE = 2'b00,
		PBMR_PAUSE_SYM = 2'b01,
		PBMR_PAUSE_ASYM = 2'b10,
		PBMR_PAUSE_BOTH = 2'b11
	} pbmr_pause_t;
endpackage

// ===== pbmr_latch_flag.sv
// one latching status flag, latching high or latching low
module pbmr_latch_flag #(
	parameter bit LATCH_LOW = 1'b0
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// condition level and read clear
	input wire logic level_in,
	input wire logic clear_in,
	// latched value
	output logic flag_out
);
	//----------------------------------------------------------------------
	// latch
	//----------------------------------------------------------------------
	// the event always wins over a read in the same cycle
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			flag_out <= 1'b0;
		else if (LATCH_LOW)
		begin
			if (!level_in)
				flag_out <= 1'b0; // loss holds flag low
			else if (clear_in)
				flag_out <= 1'b1; // read reloads live level
		end
		else
		begin
			if (level_in)
				flag_out <= 1'b1; // event sets and holds
			else if (clear_in)
				flag_out <= 1'b0; // read clears
		end
	end
endmodule // pbmr_latch_flag

// ===== pbmr_regs_assertions.sv
// port checker for the phy register bank
module pbmr_regs_assertions #(
	parameter int DATA_W = 16,
	parameter int INDEX_W = 5
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// indexed access
	input wire logic [INDEX_W-1:0] index_in,
	input wire logic wr_strobe_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic rd_strobe_in,
	input wire logic [DATA_W-1:0] rd_data_out,
	input wire logic rd_valid_out,
	// controls toward the phy core
	input wire logic soft_reset_out,
	input wire logic an_restart_out,
	input wire logic an_enable_out,
	input wire logic loopback_out,
	input wire logic power_down_out,
	input wire logic [1:0] pause_cfg_out,
	input wire logic [DATA_W-1:0] advert_out
);
	// one clock domain, checks idle in reset
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	//--------
	// access
	//--------
	a_read_answer: assert property (
		rd_strobe_in |=> rd_valid_out) else $error("read strobe got no answer");
	a_answer_cause: assert property (
		rd_valid_out |-> $past(rd_strobe_in)) else $error("answer without read strobe");
	a_status_fixed: assert property (
		rd_valid_out && $past(rd_strobe_in && index_in == 5'h01)
		|-> (rd_data_out & 16'hFFC9) == 16'h7809) else $error("status fixed bits wrong");
	a_unmapped_zero: assert property (
		rd_valid_out && $past(rd_strobe_in && index_in > 5'h04)
		|-> rd_data_out == 16'h0000) else $error("unmapped index read not zero");

	//--------
	// self-clearing controls
	//--------
	a_restart_pulse: assert property (
		an_restart_out |=> !an_restart_out) else $error("restart longer than one cycle");
	a_restart_cause: assert property (
		an_restart_out |-> $past(wr_strobe_in && index_in == 5'h00 && wr_data_in[9], 2))
		else $error("restart without control write");
	a_reset_length: assert property (
		$rose(soft_reset_out) |-> ##19 soft_reset_out ##1 !soft_reset_out)
		else $error("soft reset length wrong");
	a_reset_cause: assert property (
		$rose(soft_reset_out) |-> $past(wr_strobe_in && index_in == 5'h00 && wr_data_in[15], 2))
		else $error("soft reset without control write");
	a_reset_defaults: assert property (
		soft_reset_out |=> !loopback_out && !power_down_out && an_enable_out
		&& advert_out == 16'h01E1) else $error("soft reset left non-default controls");

	//--------
	// advertisement
	//--------
	a_pause_single: assert property (
		pause_cfg_out != 2'b11) else $error("both pause modes configured");
	a_advert_reserved: assert property (
		(advert_out & 16'hD200) == 16'h0000) else $error("reserved advert bits set");
endmodule // pbmr_regs_assertions

bind pbmr_regs pbmr_regs_assertions #(.DATA_W(DATA_W), .INDEX_W(INDEX_W)) pbmr_regs_assertions_i (
	.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .index_in(index_in),
	.wr_strobe_in(wr_strobe_in), .wr_data_in(wr_data_in), .rd_strobe_in(rd_strobe_in),
	.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .soft_reset_out(soft_reset_out),
	.an_restart_out(an_restart_out), .an_enable_out(an_enable_out),
	.loopback_out(loopback_out), .power_down_out(power_down_out),
	.pause_cfg_out(pause_cfg_out), .advert_out(advert_out));

// ===== pbmr_mac_model.sv
// management master model issuing indexed reads and writes
module pbmr_mac_model (
	// clock
	input wire logic ref_clk_in,
	// indexed access toward the bank
	output logic [4:0] index_out,
	output logic wr_strobe_out,
	output logic [15:0] wr_data_out,
	output logic rd_strobe_out,
	input wire logic [15:0] rd_data_in,
	input wire logic rd_valid_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial
	begin
		index_out = 5'h1F;
		wr_strobe_out = 1'b0;
		wr_data_out = 16'h0000;
		rd_strobe_out = 1'b0;
	end

	// one write, held for one sampling edge, bus scrambled after
	task automatic mgmt_write(input logic [4:0] idx, input logic [15:0] data);
		@(posedge ref_clk_in);
		index_out <= idx;
		wr_data_out <= data;
		wr_strobe_out <= 1'b1;
		@(posedge ref_clk_in);
		wr_strobe_out <= 1'b0;
		index_out <= ~idx;
		wr_data_out <= ~data;
	endtask

	// one read, answer taken one cycle after the strobe edge
	task automatic mgmt_read(input logic [4:0] idx, output logic [15:0] data, output logic ok);
		@(posedge ref_clk_in);
		index_out <= idx;
		rd_strobe_out <= 1'b1;
		@(posedge ref_clk_in);
		rd_strobe_out <= 1'b0;
		index_out <= ~idx;
		#1;
		ok = rd_valid_in;
		data = rd_data_in;
	endtask

	// soft reset write carries no other bit
	task automatic soft_reset();
		mgmt_write(5'h00, 16'h8000);
	endtask

	// autonegotiation off in an earlier write, then power down
	task automatic power_down();
		mgmt_write(5'h00, 16'h0000);
		mgmt_write(5'h00, 16'h0800);
	endtask
endmodule // pbmr_mac_model

// ===== test_phy_basic_mgmt_registers.sv
// self-checking bench for the phy register bank
module test_phy_basic_mgmt_registers;
	timeunit 1ns;
	timeprecision 1ns;

	// one table row: optional write, then read back
	typedef struct packed {logic wr; logic [4:0] idx; logic [15:0] wdata; logic [15:0] exp;} pbmr_row_t;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [4:0] index_in;
	logic wr_strobe_in, rd_strobe_in, rd_valid_out;
	logic [15:0] wr_data_in, rd_data_out, advert_out;
	// phy core side levels
	logic link_up_in = 1'b0, remote_fault_in = 1'b0, jabber_in = 1'b0, an_complete_in = 1'b0;
	logic an_speed_100_in = 1'b0, an_full_duplex_in = 1'b0;
	logic [1:0] partner_pause_in = 2'b00;
	logic soft_reset_out, an_restart_out, an_enable_out, loopback_out, power_down_out;
	logic col_test_out, speed_100_out, full_duplex_out;
	logic [1:0] pause_cfg_out;
	int errors = 0, comparisons = 0, cycles = 0, restarts = 0;
	pbmr_row_t rows [0:15] = '{
		'{1'b0, 5'h00, 16'h0000, 16'h3000}, '{1'b0, 5'h01, 16'h0000, 16'h7809},
		'{1'b0, 5'h02, 16'h0000, 16'h1234}, '{1'b0, 5'h03, 16'h0000, 16'h5670},
		'{1'b0, 5'h04, 16'h0000, 16'h01E1}, '{1'b0, 5'h05, 16'h0000, 16'h0000},
		'{1'b1, 5'h00, 16'h45FF, 16'h4180}, '{1'b1, 5'h00, 16'h2800, 16'h2800},
		'{1'b1, 5'h04, 16'hFFFF, 16'h2DFF}, '{1'b1, 5'h04, 16'h0401, 16'h0401},
		'{1'b1, 5'h04, 16'h0801, 16'h0801}, '{1'b1, 5'h04, 16'h0C01, 16'h0C01},
		'{1'b1, 5'h02, 16'hA5A5, 16'hA5A5}, '{1'b1, 5'h03, 16'h5A5A, 16'h5A5A},
		'{1'b1, 5'h01, 16'hFFFF, 16'h7809}, '{1'b1, 5'h1F, 16'hFFFF, 16'h0000}};

	pbmr_regs pbmr_regs_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .index_in(index_in),
		.wr_strobe_in(wr_strobe_in), .wr_data_in(wr_data_in), .rd_strobe_in(rd_strobe_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .link_up_in(link_up_in),
		.remote_fault_in(remote_fault_in), .jabber_in(jabber_in), .an_complete_in(an_complete_in),
		.an_speed_100_in(an_speed_100_in), .an_full_duplex_in(an_full_duplex_in),
		.partner_pause_in(partner_pause_in), .soft_reset_out(soft_reset_out),
		.an_restart_out(an_restart_out), .an_enable_out(an_enable_out),
		.loopback_out(loopback_out), .power_down_out(power_down_out), .col_test_out(col_test_out),
		.speed_100_out(speed_100_out), .full_duplex_out(full_duplex_out),
		.pause_cfg_out(pause_cfg_out), .advert_out(advert_out));
	pbmr_mac_model pbmr_mac_model_i (.ref_clk_in(ref_clk_in), .index_out(index_in),
		.wr_strobe_out(wr_strobe_in), .wr_data_out(wr_data_in), .rd_strobe_out(rd_strobe_in),
		.rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out));

	// clock, restart pulse counter and hang guard
	always #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (an_restart_out === 1'b1)
			restarts++;
		if (cycles == 3000)
		begin
			errors++;
			report_and_stop();
		end
	end

	// one comparison, counted
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// read one register and compare answer
	task automatic read_check(input logic [4:0] idx, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		pbmr_mac_model_i.mgmt_read(idx, d, ok);
		check("read valid", 16'h0001, 16'(ok));
		check($sformatf("index %0d", idx), exp, d);
	endtask

	// counts and verdict
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		int n;
		repeat (20) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		// table: reset values, access kinds, unmapped places
		foreach (rows[i])
		begin
			if (rows[i].wr)
				pbmr_mac_model_i.mgmt_write(rows[i].idx, rows[i].wdata);
			read_check(rows[i].idx, rows[i].exp);
		end
		$display("test table done");
		// soft reset: self-clearing, writes dropped, defaults back
		pbmr_mac_model_i.soft_reset();
		read_check(5'h00, 16'hB000);
		check("soft reset", 16'h0001, 16'(soft_reset_out));
		pbmr_mac_model_i.mgmt_write(5'h04, 16'h0000);
		repeat (22) @(posedge ref_clk_in);
		read_check(5'h00, 16'h3000);
		read_check(5'h04, 16'h01E1);
		read_check(5'h02, 16'hA5A5);
		$display("test soft reset done");
		// restart: one pulse, bit reads back zero
		n = restarts;
		pbmr_mac_model_i.mgmt_write(5'h00, 16'h1200);
		read_check(5'h00, 16'h1000);
		check("restarts", 16'(n + 1), 16'(restarts));
		$display("test restart done");
		// negotiated values override manual ones
		@(posedge ref_clk_in);
		an_speed_100_in <= 1'b1;
		an_full_duplex_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		check("an speed", 16'h0001, 16'(speed_100_out));
		check("an duplex", 16'h0001, 16'(full_duplex_out));
		pbmr_mac_model_i.mgmt_write(5'h00, 16'h0100);
		repeat (3) @(posedge ref_clk_in);
		check("manual speed", 16'h0000, 16'(speed_100_out));
		check("manual duplex", 16'h0001, 16'(full_duplex_out));
		pbmr_mac_model_i.mgmt_write(5'h00, 16'h4080);
		repeat (3) @(posedge ref_clk_in);
		check("loopback", 16'h0001, 16'(loopback_out));
		check("col test", 16'h0001, 16'(col_test_out));
		pbmr_mac_model_i.power_down();
		repeat (3) @(posedge ref_clk_in);
		check("power down", 16'h0001, 16'(power_down_out));
		check("an enable", 16'h0000, 16'(an_enable_out));
		pbmr_mac_model_i.mgmt_write(5'h00, 16'h1000);
		$display("test controls done");
		// latched flags: events of one cycle, link drop of one cycle
		@(posedge ref_clk_in);
		link_up_in <= 1'b1;
		read_check(5'h01, 16'h7809);
		read_check(5'h01, 16'h780D);
		@(posedge ref_clk_in);
		{remote_fault_in, jabber_in, link_up_in} <= 3'b110;
		@(posedge ref_clk_in);
		{remote_fault_in, jabber_in, link_up_in, an_complete_in} <= 4'b0011;
		repeat (3) @(posedge ref_clk_in);
		read_check(5'h01, 16'h783B);
		read_check(5'h01, 16'h782D);
		$display("test flags done");
		// both pause modes resolve to one
		pbmr_mac_model_i.mgmt_write(5'h04, 16'h0DE1);
		for (int p = 0; p < 4; p++)
		begin
			@(posedge ref_clk_in);
			partner_pause_in <= 2'(p);
			repeat (3) @(posedge ref_clk_in);
			check("pause", p[0] ? 16'h0001 : {14'h0000, p[1], 1'b0}, 16'(pause_cfg_out));
		end
		check("advert", 16'h0DE1, advert_out);
		$display("test pause done");
		report_and_stop();
	end
endmodule // test_phy_basic_mgmt_registers
